//--- rtl/magstripe_defines.vh
// Offsets, field positions, default parameter bytes and return codes
`ifndef MAGSTRIPE_DEFINES_VH
`define MAGSTRIPE_DEFINES_VH

`define TRACK_BYTES 8
`define SET_BYTES 24
`define FLD_PARITY 0
`define FLD_WIDTH 1
`define FLD_PSTART 2
`define FLD_ASTART 3
`define FLD_PEND 4
`define FLD_AEND 5
`define FLD_FORMAT 6
`define FLD_LEAD 7
`define FMT_DOUBLE_BIT 7

`define ADDR_STAGE_LAST 8'h17
`define ADDR_COMMAND 8'h18
`define ADDR_STATUS 8'h19
`define ADDR_HANDLE 8'h1a
`define ADDR_ACTIVE_FIRST 8'h20
`define ADDR_ACTIVE_LAST 8'h37

`define CMD_OPEN_BIT 0
`define CMD_CLOSE_BIT 1
`define CMD_LOAD_BIT 2

`define RC_OK 16'd0
`define RC_BAD_HANDLE 16'd1540
`define RC_UNAVAILABLE 16'd1541
`define RC_TRACK1 16'd1545
`define RC_TRACK2 16'd1546
`define RC_TRACK3 16'd1547

`define T1_DEFAULTS 64'h02_07_05_05_1f_1f_00_0a
`define T2_DEFAULTS 64'h02_05_0b_0d_0f_0c_85_3c
`define T3_DEFAULTS 64'h02_05_0b_0d_0f_0c_85_3c

`endif

//--- rtl/char_parity.v
// Parity insertion and check for one magnetic character of 5 to 7 bits
module char_parity (
  input wire [7:0] data, // Character, parity bit at width-1 when checked
  input wire [2:0] width, // Bits per character including parity
  input wire odd, // High for odd parity
  output wire [7:0] char_out, // Data bits with parity bit inserted
  output wire parity_ok // Received character has the selected parity
);
  wire [7:0] full_mask;
  wire [7:0] data_mask;
  wire [7:0] bits;
  wire par;

  assign full_mask = (8'h01 << width) - 8'h01;
  assign data_mask = full_mask >> 1;
  assign bits = data & data_mask;
  assign par = (^bits) ^ odd;
  assign char_out = bits | ({7'h00, par} << (width - 3'h1));
  assign parity_ok = ((^(data & full_mask)) == odd);
endmodule // char_parity

//--- rtl/magstripe_track_format_control.v
// Track format control: parameter set, load checks, encode and read framing
// Contract
// - Parameter set is 24 bytes, three 8-byte track groups in order.
// - Parity codes 00..03 pick odd/even data and check-character parity.
// - Read path checks every recovered character against data parity.
// - Encode adds data parity, builds check character with its own parity.
// - Width 5, 6 or 7 counts the parity bit.
// - Host characters are 8-bit bytes without parity.
// - Primary or alternate start sentinel begins a read record.
// - Primary or alternate end sentinel ends a read record.
// - Encode uses primary sentinels only.
// - Format bit 7 selects double record, bits 0-6 give zero count.
// - Double record is encoded twice with zeros between copies; second copy stops after REPLAY_DEPTH stored characters.
// - Leading zeros precede first record; read ignores format and lead.
// - Track one defaults 02,07,05,05,1F,1F,00,0A on open.
// - Track three defaults 02,05,0B,0D,0F,0C,85,3C on open.
// - Load rejected unless every parity code is 00 to 03.
// - Load rejected unless every width is 05, 06 or 07.
// - Load rejected if any sentinel field is zero.
// - Load rejected on zero leading count or zero double-record gap.
// - Rejection codes 1545-1547 per track; 1540 bad handle, 1541 unavailable.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`include "magstripe_defines.vh"
module magstripe_track_format_control #(
  parameter REPLAY_DEPTH = 128
) (
  input wire clk, // 100 MHz clock
  input wire reset, // Synchronous, active high
  input wire [7:0] reg_addr, // Register index
  input wire [31:0] reg_wdata, // Write data
  input wire reg_write, // Write strobe
  input wire reg_read, // Read strobe
  output reg [31:0] reg_rdata, // Read data, cycle after strobe
  input wire enc_start, // Start an encode on enc_track
  input wire [1:0] enc_track, // Encode track 0..2
  input wire enc_valid, // Host data byte valid
  input wire [7:0] enc_data, // Host data byte
  input wire enc_last, // Last data byte of record
  output wire enc_ready, // Byte accepted when valid and ready
  output wire enc_busy, // Encode in progress
  output reg media_valid, // Media character valid
  output reg [7:0] media_char, // Media character with parity
  input wire media_ready, // Media side takes character
  input wire rd_valid, // Recovered media character valid
  input wire [7:0] rd_char, // Recovered character with parity
  input wire [1:0] rd_track, // Track being read
  output reg host_valid, // Host read byte valid, one cycle
  output reg [7:0] host_data, // Host read byte without parity
  output reg rd_parity_error, // Parity failure pulse
  output reg rd_record_start, // Start sentinel seen pulse
  output reg rd_record_end // End sentinel seen pulse
);
  localparam S_IDLE = 8'h01;
  localparam S_LEAD = 8'h02;
  localparam S_START = 8'h04;
  localparam S_DATA = 8'h08;
  localparam S_END = 8'h10;
  localparam S_CHECK = 8'h20;
  localparam S_GAP = 8'h40;
  localparam S_REPLAY = 8'h80;

  reg [7:0] stage [0:`SET_BYTES-1];
  reg [7:0] active [0:`SET_BYTES-1];
  reg [7:0] replay [0:REPLAY_DEPTH-1];
  reg [15:0] result_code;
  reg [15:0] session_handle;
  reg opened;
  reg overflow;
  reg [7:0] state;
  reg [7:0] next_state;
  reg [6:0] count;
  reg [7:0] check_char;
  reg [7:0] rec_len;
  reg [7:0] rep_idx;
  reg [4:0] enc_base;
  reg in_record;
  integer i;

  wire [63:0] defaults_bus;
  wire [15:0] fail_code;
  wire [2:0] track_fail;
  wire adv;
  wire [7:0] e_par;
  wire [7:0] e_width;
  wire [7:0] e_fmt;
  wire [4:0] r_base;
  wire [7:0] r_par;
  wire [7:0] r_width;
  wire [7:0] r_data;
  wire [7:0] e_coded;
  wire r_ok;
  reg [7:0] e_src;
  reg e_odd;
  reg emit;
  reg store;

  function [7:0] default_byte;
    input integer idx;
    reg [63:0] grp;
    begin
      // Track one, track two and track three defaults
      if (idx < `TRACK_BYTES)
        grp = `T1_DEFAULTS;
      else if (idx < 2 * `TRACK_BYTES)
        grp = `T2_DEFAULTS;
      else
        grp = `T3_DEFAULTS;
      default_byte = grp[(7 - (idx % `TRACK_BYTES)) * 8 +: 8];
    end
  endfunction

  function track_bad;
    input [7:0] par;
    input [7:0] width;
    input [7:0] ps;
    input [7:0] as;
    input [7:0] pe;
    input [7:0] ae;
    input [7:0] fmt;
    input [7:0] lead;
    begin
      track_bad = (par > 8'h03);
      track_bad = track_bad | (width < 8'h05) | (width > 8'h07);
      track_bad = track_bad | (ps == 8'h00) | (as == 8'h00) | (pe == 8'h00)
        | (ae == 8'h00);
      track_bad = track_bad | (lead == 8'h00)
        | (fmt[`FMT_DOUBLE_BIT] & (fmt[6:0] == 7'h00));
    end
  endfunction

  genvar t;
  generate
    for (t = 0; t < 3; t = t + 1)
    begin : g_check
      assign track_fail[t] = track_bad(stage[t*8+`FLD_PARITY], stage[t*8+`FLD_WIDTH],
        stage[t*8+`FLD_PSTART], stage[t*8+`FLD_ASTART], stage[t*8+`FLD_PEND],
        stage[t*8+`FLD_AEND], stage[t*8+`FLD_FORMAT], stage[t*8+`FLD_LEAD]);
    end
  endgenerate

  assign fail_code = track_fail[0] ? `RC_TRACK1 :
    track_fail[1] ? `RC_TRACK2 :
    track_fail[2] ? `RC_TRACK3 : `RC_OK;

  wire cmd_write;
  assign cmd_write = reg_write && (reg_addr == `ADDR_COMMAND);

  // Parameter storage, open, close and load commands
  always @(posedge clk)
  begin
    if (reset)
    begin
      for (i = 0; i < `SET_BYTES; i = i + 1)
      begin
        stage[i] <= default_byte(i);
        active[i] <= default_byte(i);
      end
      result_code <= `RC_OK;
      session_handle <= 16'h0000;
      opened <= 1'b0;
    end
    else
    begin
      if (reg_write && (reg_addr <= `ADDR_STAGE_LAST))
        stage[reg_addr[4:0]] <= reg_wdata[7:0];
      if (cmd_write && reg_wdata[`CMD_OPEN_BIT])
      begin
        for (i = 0; i < `SET_BYTES; i = i + 1)
          active[i] <= default_byte(i);
        session_handle <= session_handle + 16'h0001;
        opened <= 1'b1;
        result_code <= `RC_OK;
      end
      else if (cmd_write && reg_wdata[`CMD_CLOSE_BIT])
        opened <= 1'b0;
      else if (cmd_write && reg_wdata[`CMD_LOAD_BIT])
      begin
        if (!opened)
          result_code <= `RC_UNAVAILABLE;
        else if (reg_wdata[31:16] != session_handle)
          result_code <= `RC_BAD_HANDLE;
        else
        begin
          result_code <= fail_code;
          if (fail_code == `RC_OK)
            for (i = 0; i < `SET_BYTES; i = i + 1)
              active[i] <= stage[i];
        end
      end
    end
  end

  // Register reads, unmapped indices read zero
  always @(posedge clk)
  begin
    if (reset)
      reg_rdata <= 32'h0000_0000;
    else if (reg_read)
    begin
      if (reg_addr <= `ADDR_STAGE_LAST)
        reg_rdata <= {24'h000000, stage[reg_addr[4:0]]};
      else if (reg_addr == `ADDR_STATUS)
        reg_rdata <= {13'h0000, overflow, enc_busy, opened, result_code};
      else if (reg_addr == `ADDR_HANDLE)
        reg_rdata <= {16'h0000, session_handle};
      else if ((reg_addr >= `ADDR_ACTIVE_FIRST) && (reg_addr <= `ADDR_ACTIVE_LAST))
        reg_rdata <= {24'h000000, active[reg_addr[4:0] - 5'h00]};
      else
        reg_rdata <= 32'h0000_0000;
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

  // Encode side parameters of the latched track
  assign e_par = active[enc_base + `FLD_PARITY];
  assign e_width = active[enc_base + `FLD_WIDTH];
  assign e_fmt = active[enc_base + `FLD_FORMAT];
  assign adv = !media_valid || media_ready;
  assign enc_busy = (state != S_IDLE);
  assign enc_ready = (state == S_DATA) && adv;

  always @*
  begin
    e_src = 8'h00;
    // data parity odd when code bit 0 clear
    e_odd = ~e_par[0];
    emit = 1'b0;
    store = 1'b0;
    next_state = state;
    case (state)
      S_IDLE:
      begin
        if (enc_start && opened)
          next_state = S_LEAD;
      end
      S_LEAD:
      begin
        emit = adv;
        if (adv && (count == 7'h01))
          next_state = S_START;
      end
      S_START:
      begin
        e_src = active[enc_base + `FLD_PSTART];
        emit = adv;
        store = adv;
        if (adv)
          next_state = S_DATA;
      end
      S_DATA:
      begin
        e_src = enc_data;
        emit = adv && enc_valid;
        store = emit;
        if (emit && enc_last)
          next_state = S_END;
      end
      S_END:
      begin
        e_src = active[enc_base + `FLD_PEND];
        emit = adv;
        store = adv;
        if (adv)
          next_state = S_CHECK;
      end
      S_CHECK:
      begin
        // check-character parity odd for codes 00 and 03
        e_src = check_char;
        e_odd = ~(e_par[0] ^ e_par[1]);
        emit = adv;
        store = adv;
        if (adv)
          next_state = e_fmt[`FMT_DOUBLE_BIT] ? S_GAP : S_IDLE;
      end
      S_GAP:
      begin
        emit = adv;
        if (adv && (count == 7'h01))
          next_state = S_REPLAY;
      end
      S_REPLAY:
      begin
        if (adv && (rep_idx + 8'h01 >= rec_len))
          next_state = S_IDLE;
      end
      default:
        next_state = S_IDLE;
    endcase
  end

  char_parity u_enc_parity (
    .data(e_src),
    .width(e_width[2:0]),
    .odd(e_odd),
    .char_out(e_coded),
    .parity_ok()
  );

  // Encode sequencer and media output register
  always @(posedge clk)
  begin
    if (reset || !opened)
    begin
      state <= S_IDLE;
      count <= 7'h00;
      check_char <= 8'h00;
      rec_len <= 8'h00;
      rep_idx <= 8'h00;
      enc_base <= 5'h00;
      overflow <= 1'b0;
      media_valid <= 1'b0;
      media_char <= 8'h00;
    end
    else
    begin
      state <= next_state;
      if (media_ready && media_valid)
        media_valid <= 1'b0;
      if (emit)
      begin
        media_valid <= 1'b1;
        media_char <= e_coded;
      end
      if (state == S_IDLE && enc_start)
      begin
        enc_base <= (enc_track > 2'd2) ? 5'd16 : {enc_track, 3'b000};
        count <= active[((enc_track > 2'd2) ? 5'd16 : {enc_track, 3'b000})
          + `FLD_LEAD][6:0];
        check_char <= 8'h00;
        rec_len <= 8'h00;
        overflow <= 1'b0;
      end
      if ((state == S_LEAD || state == S_GAP) && adv)
        count <= count - 7'h01;
      // running check over sentinels and data
      if (emit && (state == S_START || state == S_DATA || state == S_END))
        check_char <= check_char ^ e_src;
      if (store)
      begin
        // Record longer than the replay store loses its second copy tail
        if (rec_len < REPLAY_DEPTH)
        begin
          replay[rec_len[6:0]] <= e_coded;
          rec_len <= rec_len + 8'h01;
        end
        else
          overflow <= 1'b1;
      end
      if (state == S_CHECK && adv)
      begin
        count <= e_fmt[6:0];
        rep_idx <= 8'h00;
      end
      if (state == S_REPLAY && adv)
      begin
        media_valid <= 1'b1;
        media_char <= replay[rep_idx[6:0]];
        rep_idx <= rep_idx + 8'h01;
      end
    end
  end

  // read path uses no format or lead field
  assign r_base = (rd_track > 2'd2) ? 5'd16 : {rd_track, 3'b000};
  assign r_par = active[r_base + `FLD_PARITY];
  assign r_width = active[r_base + `FLD_WIDTH];

  char_parity u_rd_parity (
    .data(rd_char),
    .width(r_width[2:0]),
    .odd(~r_par[0]),
    .char_out(),
    .parity_ok(r_ok)
  );

  // parity stripped before matching
  // Sentinels are stored without parity, so compare bare data bits
  assign r_data = rd_char & ((8'h01 << (r_width[2:0] - 3'h1)) - 8'h01);

  // Read framing and host delivery
  always @(posedge clk)
  begin
    if (reset || !opened)
    begin
      in_record <= 1'b0;
      host_valid <= 1'b0;
      host_data <= 8'h00;
      rd_parity_error <= 1'b0;
      rd_record_start <= 1'b0;
      rd_record_end <= 1'b0;
    end
    else
    begin
      host_valid <= 1'b0;
      rd_parity_error <= 1'b0;
      rd_record_start <= 1'b0;
      rd_record_end <= 1'b0;
      if (rd_valid)
      begin
        rd_parity_error <= !r_ok;
        if (!in_record && ((r_data == active[r_base + `FLD_PSTART]) ||
          (r_data == active[r_base + `FLD_ASTART])))
        begin
          in_record <= 1'b1;
          rd_record_start <= 1'b1;
        end
        else if (in_record && ((r_data == active[r_base + `FLD_PEND]) ||
          (r_data == active[r_base + `FLD_AEND])))
        begin
          in_record <= 1'b0;
          rd_record_end <= 1'b1;
        end
        else if (in_record)
        begin
          host_valid <= 1'b1;
          host_data <= r_data;
        end
      end
    end
  end
endmodule // magstripe_track_format_control

//--- verification/magstripe_properties.sv
// Port-level assertions for the track format controller
module magstripe_properties (
  input wire logic clk, // Clock
  input wire logic reset, // Synchronous reset
  input wire logic reg_read, // Read strobe
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic enc_start, // Encode start
  input wire logic enc_ready, // Byte accept
  input wire logic enc_busy, // Encode active
  input wire logic media_valid, // Media char valid
  input wire logic [7:0] media_char, // Media char
  input wire logic media_ready, // Media accept
  input wire logic rd_valid, // Recovered char valid
  input wire logic host_valid, // Host byte valid
  input wire logic rd_parity_error, // Parity pulse
  input wire logic rd_record_start, // Start pulse
  input wire logic rd_record_end // End pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  perr_cause_a:
    assert property (rd_parity_error |-> $past(rd_valid)) else $error("parity pulse without char");
  start_cause_a:
    assert property (rd_record_start |-> $past(rd_valid) && !rd_record_end)
    else $error("start pulse without char");
  end_cause_a:
    assert property (rd_record_end |-> $past(rd_valid)) else $error("end pulse without char");
  host_cause_a:
    assert property (host_valid |-> $past(rd_valid) && !rd_record_start && !rd_record_end)
    else $error("host byte without data char");
  media_hold_a:
    assert property (media_valid && !media_ready |=> media_valid && $stable(media_char))
    else $error("media char dropped");
  media_width_a:
    assert property (media_valid |-> media_char[7] == 1'b0) else $error("media char too wide");
  enc_launch_a:
    assert property ($rose(enc_busy) |-> $past(enc_start) ##[1:2] media_valid)
    else $error("encode launch wrong");
  ready_busy_a:
    assert property (enc_ready |-> enc_busy) else $error("ready while idle");
  rdata_quiet_a:
    assert property (!reg_read |=> reg_rdata == 32'h0) else $error("read data outside slot");
endmodule // magstripe_properties

bind magstripe_track_format_control magstripe_properties chk (.clk(clk), .reset(reset),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .enc_start(enc_start), .enc_ready(enc_ready),
  .enc_busy(enc_busy), .media_valid(media_valid), .media_char(media_char),
  .media_ready(media_ready), .rd_valid(rd_valid), .host_valid(host_valid),
  .rd_parity_error(rd_parity_error), .rd_record_start(rd_record_start),
  .rd_record_end(rd_record_end));

//--- verification/media_model.sv
// Write head model: takes media characters with periodic stalls
module media_model (
  input wire logic clk, // Clock
  input wire logic reset, // Synchronous reset
  input wire logic media_valid, // Char offered
  input wire logic [7:0] media_char, // Char with parity
  output logic media_ready // Head takes char
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt = 2'h0;
  logic [7:0] got[$];
  // Stall one cycle in four so hold behaviour is exercised
  assign media_ready = (cnt != 2'h3);
  always @(posedge clk)
  begin
    cnt <= reset ? 2'h0 : cnt + 2'h1;
    if (!reset && media_valid && media_ready)
      got.push_back(media_char);
  end
endmodule // media_model

//--- verification/testbench.sv
// Self-checking bench: registers, load checks, read framing, encode stream
`include "magstripe_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [191:0] DEF = 192'h02070505_1f1f000a_02050b0d_0f0c853c_02050b0d_0f0c853c;
  logic clk = 0, reset = 1, reg_write = 0, reg_read = 0, enc_start = 0, enc_valid = 0;
  logic enc_last = 0, rd_valid = 0;
  logic [7:0] reg_addr = 8'h00, enc_data = 8'h00, rd_char = 8'h00;
  logic [31:0] reg_wdata = 32'h0, v;
  logic [1:0] enc_track = 2'h0, rd_track = 2'h2;
  logic [31:0] reg_rdata;
  logic enc_ready, enc_busy, media_valid, media_ready, host_valid, rd_parity_error;
  logic rd_record_start, rd_record_end;
  logic [7:0] media_char, host_data, exq[$];
  logic [15:0] h = 16'h0;
  logic [23:0] bad[7] = '{24'h000004, 24'h010104, 24'h020108, 24'h000300, 24'h010500,
    24'h020700, 24'h000680};
  int mismatches = 0, n_compared = 0;
  always #5 clk = ~clk;
  magstripe_track_format_control DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .enc_start(enc_start), .enc_track(enc_track), .enc_valid(enc_valid), .enc_data(enc_data),
    .enc_last(enc_last), .enc_ready(enc_ready), .enc_busy(enc_busy),
    .media_valid(media_valid), .media_char(media_char), .media_ready(media_ready),
    .rd_valid(rd_valid), .rd_char(rd_char), .rd_track(rd_track), .host_valid(host_valid),
    .host_data(host_data), .rd_parity_error(rd_parity_error),
    .rd_record_start(rd_record_start), .rd_record_end(rd_record_end));
  media_model M (.clk(clk), .reset(reset), .media_valid(media_valid),
    .media_char(media_char), .media_ready(media_ready));
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1;
    @(posedge clk);
    reg_write <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1;
    @(posedge clk);
    reg_read <= 0;
    #1 v = reg_rdata;
  endtask
  task stage_defaults;
    for (int i = 0; i < 24; i++)
      wr(i, DEF[8*(23-i)+:8]);
  endtask
  task rc_is(input logic [15:0] e);
    rd(`ADDR_STATUS);
    chk("result code", e, v[15:0]);
  endtask
  task rd_send(input logic [7:0] ch, input logic [2:0] e, input logic hv);
    @(posedge clk);
    rd_valid <= 1;
    rd_char <= ch;
    @(posedge clk);
    rd_valid <= 0;
    #1 chk("start end perr", e, {rd_record_start, rd_record_end, rd_parity_error});
    if (hv)
      chk("host byte", {1'b1, ch}, {host_valid, host_data});
  endtask
  // Width 5 character: four data bits, parity at bit 4
  function logic [7:0] mc(input logic [7:0] d, input logic odd);
    mc = {3'b000, odd ? ~^d[3:0] : ^d[3:0], d[3:0]};
  endfunction
  task push_rec(input logic dodd, input logic codd);
    exq.push_back(mc(8'h0b, dodd));
    exq.push_back(mc(8'h01, dodd));
    exq.push_back(mc(8'h02, dodd));
    exq.push_back(mc(8'h0f, dodd));
    exq.push_back(mc(8'h07, codd));
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #400000;
    mismatches++;
    close_out;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 0;
    wr(`ADDR_COMMAND, 32'h4);
    rc_is(`RC_UNAVAILABLE);
    wr(`ADDR_COMMAND, 32'h1);
    h = h + 1;
    rd(`ADDR_HANDLE);
    chk("handle", h, v);
    for (int i = 0; i < 24; i++)
    begin
      rd(`ADDR_ACTIVE_FIRST + i);
      chk("default byte", DEF[8*(23-i)+:8], v);
    end
    rd(8'h40);
    chk("unmapped", 0, v);
    wr(`ADDR_ACTIVE_FIRST, 32'hff);
    rd(`ADDR_ACTIVE_FIRST);
    chk("read only", 32'h02, v);
    $display("test defaults done");
    rd_send(8'h0d, 3'b100, 0);
    rd_send(8'h01, 3'b000, 1);
    rd_send(8'h11, 3'b001, 0);
    rd_send(8'h1c, 3'b010, 0);
    rd_send(8'h0b, 3'b100, 0);
    rd_send(8'h1f, 3'b010, 0);
    $display("test read framing done");
    stage_defaults;
    wr(`ADDR_COMMAND, {h + 16'h1, 16'h4});
    rc_is(`RC_BAD_HANDLE);
    foreach (bad[k])
    begin
      stage_defaults;
      wr(bad[k][23:16] * 8 + bad[k][15:8], bad[k][7:0]);
      wr(`ADDR_COMMAND, {h, 16'h4});
      rc_is(`RC_TRACK1 + bad[k][23:16]);
      rd(`ADDR_ACTIVE_FIRST + bad[k][23:16] * 8 + bad[k][15:8]);
      chk("kept byte", DEF[8*(23-bad[k][23:16]*8-bad[k][15:8])+:8], v);
    end
    $display("test load checks done");
    for (int c = 0; c < 4; c++)
    begin
      for (int i = 0; i < 8; i++)
        wr(i, {8'h02, 8'h05, 8'h0b, 8'h0b, 8'h0f, 8'h0f, 8'h00, 8'h02} >> (8 * (7 - i)));
      wr(`FLD_PARITY, c);
      wr(`FLD_FORMAT, c == 0 ? 32'h81 : 32'h00);
      wr(`ADDR_COMMAND, {h, 16'h4});
      rc_is(`RC_OK);
      exq.delete();
      M.got.delete();
      repeat (2) exq.push_back(mc(8'h00, !c[0]));
      push_rec(!c[0], c == 0 || c == 3);
      if (c == 0)
      begin
        exq.push_back(mc(8'h00, 1'b1));
        push_rec(1'b1, 1'b1);
      end
      @(posedge clk);
      enc_start <= 1;
      @(posedge clk);
      enc_start <= 0;
      for (int b = 1; b < 3; b++)
      begin
        enc_valid <= 1;
        enc_data <= b;
        enc_last <= (b == 2);
        for (int t = 0; t < 200; t++)
        begin
          @(negedge clk);
          if (enc_ready === 1'b1)
            break;
        end
        @(posedge clk);
      end
      enc_valid <= 0;
      enc_last <= 0;
      for (int t = 0; t < 300 && (enc_busy !== 1'b0 || media_valid !== 1'b0); t++)
        @(negedge clk);
      chk("stream length", exq.size(), M.got.size());
      foreach (exq[i])
        chk("media char", exq[i], M.got[i]);
    end
    $display("test encode done");
    wr(`ADDR_COMMAND, 32'h2);
    wr(`ADDR_COMMAND, {h, 16'h4});
    rc_is(`RC_UNAVAILABLE);
    chk("opened flag", 0, v[16]);
    $display("test close done");
    close_out;
  end
endmodule // testbench
